// ===== rtl/srd_pkg.sv
// srd_pkg: constants and carrier types for the segment/ring decoder and
// effective-address former. assumes a 32-bit virtual address.
package srd_pkg;
  localparam int AW = 32;
  localparam int SEG_HI = 31;
  localparam int SEG_LO = 29;
  localparam int SEG_W = 3;
  localparam int RING_W = 3;
  localparam int TID_W = 5;
  localparam int IMM16_W = 16;
  localparam int PAGE_BITS = 12;
  localparam int PAGE_W = AW - PAGE_BITS;
  localparam logic [RING_W-1:0] RING_KERNEL = 3'h0;
  localparam logic [RING_W-1:0] RING_USER = 3'h4;
  localparam logic [SEG_W-1:0] SEG_FIRST_USER = 3'h4;
  localparam logic [5:0] THREADS_MP = 6'h20;
  localparam logic [5:0] THREADS_UP = 6'h01;

  // bit 2 of the encoding set means memory-indirect
  typedef enum logic [2:0] {
    SRD_ABS, SRD_DEF, SRD_IDX, SRD_RR,
    SRD_I_ABS, SRD_I_DEF, SRD_I_IDX, SRD_I_RR
  } srd_mode_t;

  typedef struct packed {
    srd_mode_t        mode;
    logic [AW-1:0]    imm;
    logic             imm16;
    logic [AW-1:0]    base_address_register;
    logic [AW-1:0]    index_address_register;
    logic             privileged;
    logic [TID_W-1:0] thread_identifier_field;
  } srd_req_t;

  typedef struct packed {
    logic [AW-1:0]     effa;
    logic [SEG_W-1:0]  segment_select_field;
    logic [RING_W-1:0] ring;
    logic [PAGE_W-1:0] page;
    logic              mode_fault;
    logic              priv_fault;
    logic              tid_fault;
  } srd_res_t;
endpackage : srd_pkg

// ===== rtl/srd_decode.sv
// srd_decode: splits virtual addresses into segment and ring, checks
// privileged instructions, forms effective addresses (direct and indirect).
// assumes pipeline and memory on i_clk; memory answers with a one-cycle ack.
// What this block does
// - 4 GB byte space in eight 512 MB segments.
// - segment number is address bits 31 down to 29.
// - segments 0..3 map one-to-one onto rings 0..3.
// - segments 4..7 all map onto user ring 4.
// - privileged instructions run only in ring 0.
// - privilege falls as ring number rises; ring 0 highest.
// - paged memory; valid address may still be absent from memory.
// - operands start at any byte; address names the first byte.
// - immediate is 16 or 32 bits, absolute or displacement.
// - direct effa is immediate, register, or register plus immediate.
// - indirect modes fetch the word at the direct address as effa.
// - register-plus-register modes only on the newest variant.
// - multiprocessing allows 32 threads by 5-bit id; otherwise one.
// - ring 0 is system-wide; interrupts are handled in ring 0.
// - bad communication register address raises a ring violation.
`timescale 1ns/1ps
module srd_decode #(
  parameter bit NEWEST_VARIANT = 1'b1,
  parameter bit MULTIPROC      = 1'b1,
  parameter bit TRACK_COMM     = 1'b1
) (
  // clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_nrst,
  // pipeline request
  input  wire logic                      i_req_valid,
  output logic                           o_req_ready,
  input  wire srd_pkg::srd_req_t         i_req,
  input  wire logic [srd_pkg::AW-1:0]    i_pc,
  input  wire logic                      i_in_interrupt,
  // result
  output logic                           o_res_valid,
  output srd_pkg::srd_res_t              o_res,
  output logic [srd_pkg::RING_W-1:0]     o_exec_ring,
  // indirect fetch
  output logic                           o_mem_req,
  output logic [srd_pkg::AW-1:0]         o_mem_addr,
  input  wire logic                      i_mem_ack,
  input  wire logic [srd_pkg::AW-1:0]    i_mem_data,
  // communication register check
  input  wire logic                      i_comm_addr_bad,
  input  wire logic                      i_trap_ack,
  output logic                           o_ring_viol
);
  import srd_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_DONE} srd_state_t;

  function automatic logic [SEG_W-1:0] seg_of(input logic [AW-1:0] a);
    seg_of = a[SEG_HI:SEG_LO];
  endfunction : seg_of

  function automatic logic [RING_W-1:0] ring_of(input logic [SEG_W-1:0] s);
    ring_of = (s >= SEG_FIRST_USER) ? RING_USER : {1'b0, s[1:0]};
  endfunction : ring_of

  srd_state_t        state_ff;
  srd_state_t        nxt_state;
  srd_req_t          req_ff;
  srd_res_t          res_ff;
  srd_res_t          nxt_res;
  logic [AW-1:0]     effa_ff;
  logic [AW-1:0]     nxt_effa;
  logic [RING_W-1:0] xring_ff;
  logic              mem_req_ff;
  logic [AW-1:0]     mem_addr_ff;
  logic              viol_ff;

  // combinational decode of the incoming request
  wire              accept    = i_req_valid && (state_ff == ST_IDLE);
  wire [AW-1:0]     imm_ext   = i_req.imm16 ?
                                {{(AW-IMM16_W){i_req.imm[IMM16_W-1]}},
                                 i_req.imm[IMM16_W-1:0]} : i_req.imm;
  wire [2:0]        mode_bits = i_req.mode;
  wire              is_ind    = mode_bits[2];
  wire              is_rr     = (mode_bits[1:0] == 2'h3);
  wire              mode_bad  = is_rr && !NEWEST_VARIANT;
  // sums are 32-bit, so carry out of bit 31 is dropped on purpose
  wire [AW-1:0]     sum_idx   = i_req.base_address_register + imm_ext;
  wire [AW-1:0]     sum_rr    = i_req.base_address_register +
                                i_req.index_address_register;
  wire [5:0]        tid_limit = MULTIPROC ? THREADS_MP : THREADS_UP;
  wire              tid_bad   = {1'b0, i_req.thread_identifier_field} >= tid_limit;
  // interrupt service always runs in the shared kernel ring
  wire [RING_W-1:0] exec_ring = i_in_interrupt ? RING_KERNEL
                                               : ring_of(seg_of(i_pc));
  // only ring 0 is privileged enough; any higher number is less privileged
  wire              priv_bad  = i_req.privileged && (exec_ring != RING_KERNEL);

  logic [AW-1:0] direct_addr;
  always_comb begin
    case (mode_bits[1:0])
      2'h0:    direct_addr = imm_ext;
      2'h1:    direct_addr = i_req.base_address_register;
      2'h2:    direct_addr = sum_idx;
      2'h3:    direct_addr = sum_rr;
      default: direct_addr = imm_ext;
    endcase
  end

  // final address split; no alignment check, any byte start is legal
  wire [AW-1:0] final_addr = (state_ff == ST_FETCH) ? i_mem_data : direct_addr;
  wire          finish     = (state_ff == ST_FETCH) ? i_mem_ack
                                                    : (accept && (!is_ind || mode_bad));

  always_comb begin
    nxt_res                      = res_ff;
    nxt_effa                     = effa_ff;
    if (finish) begin
      nxt_res.effa                 = final_addr;
      nxt_res.segment_select_field = seg_of(final_addr);
      nxt_res.ring                 = ring_of(seg_of(final_addr));
      // page number only; presence in memory is the translator's business
      nxt_res.page                 = final_addr[AW-1:PAGE_BITS];
    end
    if (accept) begin
      nxt_res.mode_fault = mode_bad;
      nxt_res.priv_fault = priv_bad;
      nxt_res.tid_fault  = tid_bad;
      nxt_effa           = direct_addr;
    end
  end

  always_comb begin
    case (state_ff)
      ST_IDLE:  nxt_state = !accept ? ST_IDLE
                          : (is_ind && !mode_bad) ? ST_FETCH : ST_DONE;
      ST_FETCH: nxt_state = i_mem_ack ? ST_DONE : ST_FETCH;
      ST_DONE:  nxt_state = ST_IDLE;
      default:  nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= ST_IDLE;
      req_ff   <= '0;
      res_ff   <= '0;
      effa_ff  <= '0;
      xring_ff <= RING_KERNEL;
    end else begin
      state_ff <= nxt_state;
      res_ff   <= nxt_res;
      effa_ff  <= nxt_effa;
      if (accept) begin
        req_ff   <= i_req;
        xring_ff <= exec_ring;
      end
    end
  end

  // fetch request held until the memory acks
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mem_req_ff  <= 1'b0;
      mem_addr_ff <= '0;
    end else if (accept && is_ind && !mode_bad) begin
      mem_req_ff  <= 1'b1;
      mem_addr_ff <= direct_addr;
    end else if (i_mem_ack) begin
      mem_req_ff  <= 1'b0;
    end
  end

  // sticky so the violation is charged to the ring that caused it;
  // a new detection in the ack cycle wins over the clear
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      viol_ff <= 1'b0;
    end else if (TRACK_COMM && i_comm_addr_bad) begin
      viol_ff <= 1'b1;
    end else if (i_trap_ack) begin
      viol_ff <= 1'b0;
    end
  end

  assign o_req_ready = (state_ff == ST_IDLE);
  assign o_res_valid = (state_ff == ST_DONE);
  assign o_res       = res_ff;
  assign o_exec_ring = xring_ff;
  assign o_mem_req   = mem_req_ff;
  assign o_mem_addr  = mem_addr_ff;
  assign o_ring_viol = viol_ff;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_seg_from_top: assert property (
    o_res_valid |-> o_res.segment_select_field == o_res.effa[31:29])
    else $error("segment field not taken from address top bits");

  a_ring_low_seg: assert property (
    o_res_valid && !o_res.effa[31] |-> o_res.ring == {1'b0, o_res.effa[30:29]})
    else $error("low segment maps to wrong ring");

  a_ring_user_seg: assert property (
    o_res_valid && o_res.effa[31] |-> o_res.ring == 3'h4)
    else $error("upper segment not in user ring");

  a_priv_ring_zero: assert property (
    o_res_valid |-> o_res.priv_fault == (req_ff.privileged && (xring_ff != 3'h0)))
    else $error("privileged check disagrees with executing ring");

  a_interrupt_ring: assert property (
    accept && i_in_interrupt |=> o_exec_ring == 3'h0)
    else $error("interrupt service not in ring zero");

  a_index_sum: assert property (
    accept && i_req.mode == SRD_IDX |=> o_res_valid
      && o_res.effa == $past(sum_idx))
    else $error("indexed address wrong or late");

  a_fetch_issue: assert property (
    accept && is_ind && !mode_bad |=> o_mem_req && o_mem_addr == $past(direct_addr))
    else $error("indirect fetch not issued at direct address");

  a_fetch_use: assert property (
    o_mem_req && i_mem_ack |=> o_res_valid && !o_mem_req && o_res.effa == $past(i_mem_data))
    else $error("fetched word not used as address");

  a_variant_gate: assert property (
    accept && is_rr && !is_ind |=> o_res_valid && o_res.mode_fault == !NEWEST_VARIANT)
    else $error("register pair mode gating wrong");

  // the indirect pair form must never reach memory on older variants
  a_variant_nofetch: assert property (
    accept && is_rr && is_ind && !NEWEST_VARIANT |=> o_res_valid && !o_mem_req)
    else $error("unsupported pair mode issued a fetch");

  a_tid_limit: assert property (
    o_res_valid |-> o_res.tid_fault ==
      ({1'b0, req_ff.thread_identifier_field} >= (MULTIPROC ? 6'h20 : 6'h01)))
    else $error("thread id limit check wrong");

  a_comm_viol: assert property (
    i_comm_addr_bad && TRACK_COMM |=> o_ring_viol [*2] or (o_ring_viol ##1 !o_ring_viol))
    else $error("comm address fault not flagged");

  a_viol_clear: assert property (
    o_ring_viol && i_trap_ack && !i_comm_addr_bad |=> !o_ring_viol)
    else $error("ring violation not cleared by trap ack");

  // the result strobe is a single-cycle pulse, then the block is free again
  a_res_pulse: assert property (
    o_res_valid |=> !o_res_valid && o_req_ready)
    else $error("result strobe longer than one cycle");

  a_mem_hold: assert property (
    o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
    else $error("fetch request dropped before ack");

  a_no_fetch_direct: assert property (
    accept && !is_ind |=> !o_mem_req)
    else $error("direct mode issued a memory fetch");

  a_page_bits: assert property (
    o_res_valid |-> o_res.page == o_res.effa[31:12])
    else $error("page number not the address top bits");

  a_kernel_priv_ok: assert property (
    o_res_valid && o_exec_ring == 3'h0 |-> !o_res.priv_fault)
    else $error("privileged op refused in ring zero");

  // every ring above zero is less privileged, so all of them refuse
  a_outer_priv_bad: assert property (
    o_res_valid && o_exec_ring != 3'h0 |-> o_res.priv_fault == req_ff.privileged)
    else $error("outer ring allowed a privileged op");

  a_direct_abs: assert property (
    accept && i_req.mode == SRD_ABS |=> o_res_valid && o_res.effa == $past(imm_ext))
    else $error("absolute address wrong or late");

  a_deferred: assert property (
    accept && i_req.mode == SRD_DEF |=> o_res_valid
      && o_res.effa == $past(i_req.base_address_register))
    else $error("deferred address wrong or late");

  a_rr_sum: assert property (
    accept && i_req.mode == SRD_RR && NEWEST_VARIANT |=> o_res_valid
      && o_res.effa == $past(sum_rr))
    else $error("register pair sum wrong or late");

  a_user_pc_ring: assert property (
    accept && !i_in_interrupt && i_pc[31] |=> o_exec_ring == 3'h4)
    else $error("user segment pc not in user ring");

  a_sys_pc_ring: assert property (
    accept && !i_in_interrupt && !i_pc[31] |=> o_exec_ring == {1'b0, $past(i_pc[30:29])})
    else $error("system segment pc in wrong ring");

  // an ack in the fetch cycle lands its word's top bits as the result segment
  a_ack_segment: assert property (
    o_mem_req && i_mem_ack |=> o_res.segment_select_field == $past(i_mem_data[31:29]))
    else $error("fetched address split into wrong segment");

  c_direct: cover property (accept && !is_ind ##1 o_res_valid);
  c_indirect: cover property (o_mem_req ##1 o_mem_req ##1 o_res_valid);
  c_priv_trap: cover property (o_res_valid && o_res.priv_fault);
  c_user_ring: cover property (o_res_valid && o_res.ring == 3'h4);
  c_reg_pair: cover property (accept && is_rr);
endmodule : srd_decode

// ===== bench/srd_mem_model.sv
// srd_mem_model: memory side answering indirect address fetches.
// assumes the fetch request is held until ack; bench sets latency per fetch.
`timescale 1ns/1ps
module srd_mem_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // fetch port
  input  wire logic        i_mem_req,
  input  wire logic [31:0] i_mem_addr,
  input  wire logic [1:0]  i_lat,
  output logic             o_mem_ack,
  output logic [31:0]      o_mem_data
);
  logic [1:0] cnt_ff;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mem_ack  <= 1'b0;
      o_mem_data <= 32'h0;
      cnt_ff     <= 2'h0;
    end else begin
      o_mem_ack  <= 1'b0;
      // stale data toggles so nothing can lean on it after the ack
      o_mem_data <= ~o_mem_data;
      if (i_mem_req && !o_mem_ack) begin
        if (cnt_ff == i_lat) begin
          o_mem_ack  <= 1'b1;
          o_mem_data <= {i_mem_addr[15:0], i_mem_addr[31:16]} ^ 32'h5a5a_a5a5;
          cnt_ff     <= 2'h0;
        end else begin
          cnt_ff <= cnt_ff + 2'h1;
        end
      end
    end
  end
endmodule : srd_mem_model

// ===== bench/segment_ring_decode_effa_tb.sv
// segment_ring_decode_effa_tb: random address requests, result queue check.
// assumes srd_pkg encodings and the one-cycle memory ack of srd_mem_model.
`timescale 1ns/1ps
module segment_ring_decode_effa_tb;
  import srd_pkg::*;
  typedef struct packed {srd_res_t res; logic [2:0] xr;} srd_exp_t;
  logic            i_clk, i_nrst, i_req_valid, i_in_interrupt;
  logic            i_comm_addr_bad, i_trap_ack, o_req_ready, o_res_valid;
  logic            o_mem_req, i_mem_ack, o_ring_viol;
  logic [1:0]      i_lat;
  logic [2:0]      o_exec_ring;
  logic [31:0]     i_pc, o_mem_addr, i_mem_data;
  srd_req_t        i_req;
  srd_res_t        o_res;
  srd_exp_t        exp_q[$];
  srd_exp_t        m_e;
  int              failures, n_tests, seed, cycles;

  srd_decode dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_req_valid(i_req_valid),
    .o_req_ready(o_req_ready), .i_req(i_req), .i_pc(i_pc), .i_in_interrupt(i_in_interrupt),
    .o_res_valid(o_res_valid), .o_res(o_res), .o_exec_ring(o_exec_ring),
    .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack),
    .i_mem_data(i_mem_data), .i_comm_addr_bad(i_comm_addr_bad),
    .i_trap_ack(i_trap_ack), .o_ring_viol(o_ring_viol));
  srd_mem_model mem_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_mem_req(o_mem_req),
    .i_mem_addr(o_mem_addr), .i_lat(i_lat), .o_mem_ack(i_mem_ack), .o_mem_data(i_mem_data));

  always #50 i_clk = ~i_clk;

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic send;
    logic [127:0] rr;
    srd_req_t     r;
    srd_exp_t     e;
    logic [31:0]  imm, a;
    rr = {$random(seed), $random(seed), $random(seed), $random(seed)};
    r = rr[105:0];
    i_pc = $random(seed);
    i_in_interrupt = ($random(seed) & 3) == 0;
    i_lat = 2'($random(seed));
    imm = r.imm16 ? {{16{r.imm[15]}}, r.imm[15:0]} : r.imm;
    case (r.mode[1:0])
      2'h0: a = imm;
      2'h1: a = r.base_address_register;
      2'h2: a = r.base_address_register + imm;
      default: a = r.base_address_register + r.index_address_register;
    endcase
    if (r.mode[2]) a = {a[15:0], a[31:16]} ^ 32'h5a5a_a5a5;
    e = '0;
    e.res.effa = a;
    e.res.segment_select_field = a[31:29];
    e.res.ring = a[31] ? RING_USER : {1'b0, a[30:29]};
    e.res.page = a[31:12];
    e.xr = i_in_interrupt ? RING_KERNEL : (i_pc[31] ? RING_USER : {1'b0, i_pc[30:29]});
    e.res.priv_fault = r.privileged && e.xr != RING_KERNEL;
    i_req = r;
    i_req_valid = 1'b1;
    while (o_req_ready !== 1'b1) @(posedge i_clk) #1;
    exp_q.push_back(e);
    @(posedge i_clk) #1;
    i_req_valid = 1'b0;
    @(posedge i_clk) #1;
  endtask : send

  always @(negedge i_clk) begin
    if (i_nrst && o_res_valid === 1'b1) begin
      if (exp_q.size() == 0) check(64'h1, 64'h0);
      else begin
        m_e = exp_q.pop_front();
        check(o_res.effa, m_e.res.effa);
        check(o_res.segment_select_field, m_e.res.segment_select_field);
        check(o_res.ring, m_e.res.ring);
        check(o_res.page, m_e.res.page);
        check(o_res.mode_fault, m_e.res.mode_fault);
        check(o_res.priv_fault, m_e.res.priv_fault);
        check(o_res.tid_fault, m_e.res.tid_fault);
        check(o_exec_ring, m_e.xr);
      end
    end
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    seed = 42514;
    {i_clk, i_nrst, i_req_valid, i_in_interrupt, i_comm_addr_bad, i_trap_ack} = '0;
    i_req = '0;
    i_pc = 32'h0;
    i_lat = 2'h0;
    repeat (2) @(posedge i_clk);
    #1 i_nrst = 1'b1;
    repeat (300) send();
    repeat (6) @(posedge i_clk);
    check(exp_q.size(), 64'h0);
    #1 i_comm_addr_bad = 1'b1;
    @(posedge i_clk) #1;
    i_comm_addr_bad = 1'b0;
    check(o_ring_viol, 64'h1);
    repeat (3) @(posedge i_clk);
    #1 check(o_ring_viol, 64'h1);
    {i_trap_ack, i_comm_addr_bad} = 2'h3;
    @(posedge i_clk) #1;
    i_comm_addr_bad = 1'b0;
    check(o_ring_viol, 64'h1);
    @(posedge i_clk) #1;
    i_trap_ack = 1'b0;
    check(o_ring_viol, 64'h0);
    end_of_test();
  end
endmodule : segment_ring_decode_effa_tb
